// [hdl/fwc_regs.vh]
`ifndef FWC_REGS_VH
`define FWC_REGS_VH
// Register byte addresses, one aligned word each
`define FWC_A_CTRL_LOW      12'h000
`define FWC_A_CTRL_HIGH     12'h004
`define FWC_A_SECT_LOW      12'h008
`define FWC_A_SECT_HIGH     12'h00C
`define FWC_A_ADDR_LOW      12'h010
`define FWC_A_ADDR_HIGH     12'h014
`define FWC_A_WD0_LOW       12'h018
`define FWC_A_WD0_HIGH      12'h01C
`define FWC_A_WD1_LOW       12'h020
`define FWC_A_WD1_HIGH      12'h024
`define FWC_A_ERROR         12'h028
`define FWC_A_STATUS        12'h02C
`define FWC_A_PROT_BASE     12'h030
// Control high bit positions
`define FWC_B_START         15
`define FWC_B_SUSPEND       14
`define FWC_B_WPROG         13
`define FWC_B_DWPROG        12
`define FWC_B_SERASE        11
`define FWC_B_SETPROT       8
`define FWC_B_MODSEL        7
// Error register bits
`define FWC_E_RESUME        0
`define FWC_E_LIMIT         1
// Protection register addresses seen through the target address
`define FWC_PROT_AHIGH      16'h000E
`define FWC_PROT_WPROT      16'hDFB4
`define FWC_PROT_ACCESS     16'hDFB8
`define FWC_PROT_PERM       16'hDFBC
`define FWC_ADDR_BIT_TWO    2
// Protection store
`define FWC_NV_WPROT        2'h0
`define FWC_NV_ACCESS       2'h1
`define FWC_NV_DISABLE      2'h2
`define FWC_NV_REENABLE     2'h3
`define FWC_NV_ERASED       16'hFFFF
`define FWC_PERM_MAX        5'h10
// Flash cycle times in ns and counts at 100 MHz
`define FWC_CLK_NS          10
`define FWC_PROG_NS         400
`define FWC_ERASE_NS        2000
`define FWC_PROG_CYC        (`FWC_PROG_NS / `FWC_CLK_NS)
`define FWC_ERASE_CYC       (`FWC_ERASE_NS / `FWC_CLK_NS)
`endif

// [hdl/fwc_prot_mem.v]
`timescale 1ns/1ps
`default_nettype none
`include "fwc_regs.vh"
// Small non-volatile protection store, registered read
module fwc_prot_mem (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        wr_en,
   input  wire [1:0]  wr_idx,
   input  wire [15:0] wr_data,
   input  wire [1:0]  rd_idx,
   output reg  [15:0] rd_data
);
   reg [15:0] mem_q [0:3];
   integer    i;

   // Erased at power-up, contents kept through reset
   initial begin
      for (i = 0; i < 4; i = i + 1) begin
         mem_q[i] = `FWC_NV_ERASED;
      end
   end

   // Programming only clears bits
   always @(posedge pclk) begin
      if (wr_en) begin
         mem_q[wr_idx] <= mem_q[wr_idx] & wr_data;
      end
   end

   // Registered read port
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= `FWC_NV_ERASED;
      end else begin
         rd_data <= mem_q[rd_idx];
      end
   end
endmodule // fwc_prot_mem
`default_nettype wire

// [hdl/fwc_ctrl.v]
// Operation
// - Select op in control high, load address/data or sectors, then start.
// - Module select bit chooses primary or extension flash for the operation.
// - Start bit, bit 15 of control high, launches the selected operation.
// - Clearing the selection bit before start cancels the pending operation.
// - Word program writes data 0 at the low/high target address.
// - Double word program writes data 0 and 1 at consecutive words.
// - Double word program ignores address bit two, even-word aligned.
// - Sector erase erases sectors marked in the sector select halves; the code never drives the halves to the flash ports.
// - Suspend bit suspends a running word, double word or erase.
// - Sector select halves read zero once the erase has completed.
// - Resume without original selection aborts and sets resume error flag.
// - Program during erase suspend needs suspend and erase bits low.
// - Program running inside an erase suspend cannot be suspended.
// - Set protection programs addressed protection register from data 0.
// - Write protection register at 0xDFB4 high 0x000E, zeros protect.
// - Write 0xFFFC at 0xDFB8 enables access and debug protection.
// - At 0xDFBC low half clears disable bit, high half re-enable bit.
// - Permanent disable and re-enable limited to 16 cycles in total.
// - Temporary unprotection returns to programmed state on reset.
`timescale 1ns/1ps
`default_nettype none
`include "fwc_regs.vh"
module fwc_ctrl (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output reg         flash_busy,
   output reg         flash_wr_en,
   output reg         flash_erase_en,
   output reg         flash_ext_sel,
   output reg  [31:0] flash_addr,
   output reg  [31:0] flash_wdata
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_PROG  = 3'h1;
   localparam ST_PROG2 = 3'h2;
   localparam ST_ERASE = 3'h3;
   localparam ST_SUSPEND_BIT  = 3'h4;
   localparam ST_PROT  = 3'h5;

   localparam [15:0] PROG_CYC  = `FWC_PROG_CYC;
   localparam [15:0] ERASE_CYC = `FWC_ERASE_CYC;

   reg [15:0] ctrl_lo_q;
   reg [15:0] ctrl_zero_high_q;
   reg [15:0] sector_select_low_q;
   reg [15:0] sector_select_high_q;
   reg [15:0] target_addr_low_q;
   reg [15:0] target_addr_high_q;
   reg [15:0] wdata0_low_q;
   reg [15:0] wdata0_high_q;
   reg [15:0] wdata1_low_q;
   reg [15:0] wdata1_high_q;
   reg [1:0]  error_reg_q;
   reg [2:0]  state_q;
   reg [15:0] cnt_q;
   reg        nested_q;    // Program running inside erase suspend
   reg        suspend_bit_kind_q; // Suspended op was erase
   reg [2:0]  suspend_bit_ret_q;
   reg [15:0] suspend_bit_cnt_q;      // Remaining count of the suspended op
   reg [4:0]  perm_cnt_q;      // Permanent actions, kept over reset
   reg [15:0] nv_wprot_q;      // Programmed protection, kept over reset
   reg [15:0] nv_access_q;
   reg [15:0] unprot_wprot_q;  // Last written protection, lost on reset
   reg [15:0] unprot_access_q;

   wire        wr_acc = psel & penable & pwrite;
   wire        rd_acc = psel & penable & ~pwrite;
   wire [15:0] wr_val = pwdata[15:0];
   wire        mapped = (paddr[1:0] == 2'b00) &&
                        (paddr <= (`FWC_A_PROT_BASE + 12'h00C));
   wire        wr_ctrl_hi = wr_acc && (paddr == `FWC_A_CTRL_HIGH);

   wire [15:0] nv_rd;
   reg         nv_wr_en;
   reg  [1:0]  nv_wr_idx;
   reg  [15:0] nv_wr_data;

   // APB always answers in the access cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Map a target address onto the protection store index
   function [2:0] prot_decode;
      input [15:0] alo;
      input [15:0] ahi;
      input [15:0] d0l;
      begin
         prot_decode = 3'b000;
         if (ahi == `FWC_PROT_AHIGH) begin
            if (alo == `FWC_PROT_WPROT)
               prot_decode = {1'b1, `FWC_NV_WPROT};
            else if (alo == `FWC_PROT_ACCESS)
               prot_decode = {1'b1, `FWC_NV_ACCESS};
            else if (alo == `FWC_PROT_PERM)
               prot_decode = (d0l != `FWC_NV_ERASED) ?
                             {1'b1, `FWC_NV_DISABLE} :
                             {1'b1, `FWC_NV_REENABLE};
         end
      end
   endfunction

   wire [2:0] prot_hit = prot_decode(target_addr_low_q, target_addr_high_q,
                                     wdata0_low_q);
   wire       prot_perm = prot_hit[2] &&
                          (prot_hit[1:0] == `FWC_NV_DISABLE ||
                           prot_hit[1:0] == `FWC_NV_REENABLE);

   // Protection write data: low half or high half of data 0
   always @* begin
      nv_wr_en   = 1'b0;
      nv_wr_idx  = prot_hit[1:0];
      nv_wr_data = wdata0_low_q;
      if (state_q == ST_PROT && cnt_q == 16'h0001 && prot_hit[2] &&
          !(prot_perm && perm_cnt_q >= `FWC_PERM_MAX)) begin
         nv_wr_en = 1'b1;
         if (prot_hit[1:0] == `FWC_NV_REENABLE)
            nv_wr_data = wdata0_high_q;
      end
   end

   fwc_prot_mem u_nv (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (nv_wr_en),
      .wr_idx  (nv_wr_idx),
      .wr_data (nv_wr_data),
      .rd_idx  (paddr[3:2]),
      .rd_data (nv_rd)
   );

   // Sequencer and register file
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_lo_q            <= 16'h0000;
         ctrl_zero_high_q     <= 16'h0000;
         sector_select_low_q  <= 16'h0000;
         sector_select_high_q <= 16'h0000;
         target_addr_low_q    <= 16'h0000;
         target_addr_high_q   <= 16'h0000;
         wdata0_low_q         <= 16'h0000;
         wdata0_high_q        <= 16'h0000;
         wdata1_low_q         <= 16'h0000;
         wdata1_high_q        <= 16'h0000;
         error_reg_q          <= 2'b00;
         state_q              <= ST_IDLE;
         cnt_q                <= 16'h0000;
         nested_q             <= 1'b0;
         suspend_bit_kind_q          <= 1'b0;
         suspend_bit_ret_q           <= ST_IDLE;
         suspend_bit_cnt_q           <= 16'h0000;
         unprot_wprot_q       <= 16'h0000;
         unprot_access_q      <= 16'h0000;
      end else begin
         // Software writes to plain registers
         if (wr_acc) begin
            case (paddr)
               `FWC_A_CTRL_LOW:  ctrl_lo_q <= wr_val;
               `FWC_A_SECT_LOW:  sector_select_low_q <= wr_val;
               `FWC_A_SECT_HIGH: sector_select_high_q <= wr_val;
               `FWC_A_ADDR_LOW:  target_addr_low_q <= wr_val;
               `FWC_A_ADDR_HIGH: target_addr_high_q <= wr_val;
               `FWC_A_WD0_LOW:   wdata0_low_q <= wr_val;
               `FWC_A_WD0_HIGH:  wdata0_high_q <= wr_val;
               `FWC_A_WD1_LOW:   wdata1_low_q <= wr_val;
               `FWC_A_WD1_HIGH:  wdata1_high_q <= wr_val;
               `FWC_A_ERROR:     error_reg_q <= error_reg_q & ~wr_val[1:0];
               default: ;
            endcase
         end
         // Control high: selection, module and start bits
         if (wr_ctrl_hi)
            ctrl_zero_high_q <= wr_val;
         if (cnt_q != 16'h0000)
            cnt_q <= cnt_q - 16'h0001;

         case (state_q)
            ST_IDLE: begin
               if (ctrl_zero_high_q[`FWC_B_START]) begin
                  if (ctrl_zero_high_q[`FWC_B_WPROG]) begin
                     state_q <= ST_PROG;
                     cnt_q   <= PROG_CYC;
                  end else if (ctrl_zero_high_q[`FWC_B_DWPROG]) begin
                     state_q <= ST_PROG;
                     cnt_q   <= PROG_CYC;
                  end else if (ctrl_zero_high_q[`FWC_B_SERASE]) begin
                     state_q <= ST_ERASE;
                     cnt_q   <= ERASE_CYC;
                  end else if (ctrl_zero_high_q[`FWC_B_SETPROT]) begin
                     state_q <= ST_PROT;
                     cnt_q   <= PROG_CYC;
                  end else begin
                     ctrl_zero_high_q[`FWC_B_START] <= 1'b0;
                  end
               end
            end
            ST_PROG, ST_PROG2: begin
               // Suspend only if not nested in erase suspend
               if (ctrl_zero_high_q[`FWC_B_SUSPEND] && !nested_q) begin
                  suspend_bit_ret_q  <= state_q;
                  suspend_bit_cnt_q  <= cnt_q;
                  suspend_bit_kind_q <= 1'b0;
                  state_q     <= ST_SUSPEND_BIT;
                  ctrl_zero_high_q[`FWC_B_START] <= 1'b0;
               end else if (cnt_q == 16'h0000) begin
                  if (state_q == ST_PROG &&
                      ctrl_zero_high_q[`FWC_B_DWPROG]) begin
                     state_q <= ST_PROG2;
                     cnt_q   <= PROG_CYC;
                  end else begin
                     state_q <= nested_q ? ST_SUSPEND_BIT : ST_IDLE;
                     nested_q <= 1'b0;
                     ctrl_zero_high_q[`FWC_B_START]  <= 1'b0;
                     ctrl_zero_high_q[`FWC_B_WPROG]  <= 1'b0;
                     ctrl_zero_high_q[`FWC_B_DWPROG] <= 1'b0;
                  end
               end
            end
            ST_ERASE: begin
               if (ctrl_zero_high_q[`FWC_B_SUSPEND]) begin
                  suspend_bit_kind_q <= 1'b1;
                  suspend_bit_ret_q  <= ST_ERASE;
                  suspend_bit_cnt_q  <= cnt_q;
                  state_q     <= ST_SUSPEND_BIT;
                  ctrl_zero_high_q[`FWC_B_START] <= 1'b0;
               end else if (cnt_q == 16'h0000) begin
                  sector_select_low_q  <= 16'h0000;
                  sector_select_high_q <= 16'h0000;
                  state_q <= ST_IDLE;
                  ctrl_zero_high_q[`FWC_B_START]  <= 1'b0;
                  ctrl_zero_high_q[`FWC_B_SERASE] <= 1'b0;
               end
            end
            ST_SUSPEND_BIT: begin
               if (ctrl_zero_high_q[`FWC_B_START] &&
                   !ctrl_zero_high_q[`FWC_B_SUSPEND]) begin
                  if (suspend_bit_kind_q && !ctrl_zero_high_q[`FWC_B_SERASE] &&
                      (ctrl_zero_high_q[`FWC_B_WPROG] ||
                       ctrl_zero_high_q[`FWC_B_DWPROG])) begin
                     nested_q <= 1'b1;
                     state_q  <= ST_PROG;
                     cnt_q    <= PROG_CYC;
                  end else if ((suspend_bit_kind_q &&
                                ctrl_zero_high_q[`FWC_B_SERASE]) ||
                               (!suspend_bit_kind_q &&
                                (ctrl_zero_high_q[`FWC_B_WPROG] ||
                                 ctrl_zero_high_q[`FWC_B_DWPROG]))) begin
                     state_q <= suspend_bit_ret_q;
                     cnt_q   <= suspend_bit_cnt_q;
                  end else begin
                     error_reg_q[`FWC_E_RESUME] <= 1'b1;
                     state_q <= ST_IDLE;
                     ctrl_zero_high_q <= 16'h0000;
                  end
               end
            end
            ST_PROT: begin
               if (cnt_q == 16'h0000) begin
                  state_q <= ST_IDLE;
                  ctrl_zero_high_q[`FWC_B_START]   <= 1'b0;
                  ctrl_zero_high_q[`FWC_B_SETPROT] <= 1'b0;
               end
               if (nv_wr_en) begin
                  if (prot_hit[1:0] == `FWC_NV_WPROT)
                     unprot_wprot_q <= wdata0_low_q;
                  if (prot_hit[1:0] == `FWC_NV_ACCESS)
                     unprot_access_q <= wdata0_low_q;
               end else if (cnt_q == 16'h0001 && prot_perm) begin
                  error_reg_q[`FWC_E_LIMIT] <= 1'b1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Programmed protection and permanent action count survive reset
   initial begin
      nv_wprot_q  = `FWC_NV_ERASED;
      nv_access_q = `FWC_NV_ERASED;
      perm_cnt_q  = 5'h00;
   end

   // Mirror of store programming, only clears bits
   always @(posedge pclk) begin
      if (nv_wr_en) begin
         if (prot_perm)
            perm_cnt_q <= perm_cnt_q + 5'h01;
         if (prot_hit[1:0] == `FWC_NV_WPROT)
            nv_wprot_q <= nv_wprot_q & wdata0_low_q;
         if (prot_hit[1:0] == `FWC_NV_ACCESS)
            nv_access_q <= nv_access_q & wdata0_low_q;
      end
   end

   // Flash array drive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_busy     <= 1'b0;
         flash_wr_en    <= 1'b0;
         flash_erase_en <= 1'b0;
         flash_ext_sel  <= 1'b0;
         flash_addr     <= 32'h0000_0000;
         flash_wdata    <= 32'h0000_0000;
      end else begin
         flash_busy     <= (state_q != ST_IDLE) && (state_q != ST_SUSPEND_BIT);
         flash_wr_en    <= (state_q == ST_PROG) || (state_q == ST_PROG2);
         flash_erase_en <= (state_q == ST_ERASE);
         flash_ext_sel  <= ~ctrl_zero_high_q[`FWC_B_MODSEL];
         flash_addr     <= {target_addr_high_q, target_addr_low_q};
         flash_wdata    <= {wdata0_high_q, wdata0_low_q};
         if (ctrl_zero_high_q[`FWC_B_DWPROG]) begin
            flash_addr[`FWC_ADDR_BIT_TWO] <= (state_q == ST_PROG2);
            if (state_q == ST_PROG2)
               flash_wdata <= {wdata1_high_q, wdata1_low_q};
         end
      end
   end

   // Read mux
   always @* begin
      prdata = 32'h0000_0000;
      if (rd_acc) begin
         case (paddr)
            `FWC_A_CTRL_LOW:  prdata[15:0] = ctrl_lo_q;
            `FWC_A_CTRL_HIGH: prdata[15:0] = ctrl_zero_high_q;
            `FWC_A_SECT_LOW:  prdata[15:0] = sector_select_low_q;
            `FWC_A_SECT_HIGH: prdata[15:0] = sector_select_high_q;
            `FWC_A_ADDR_LOW:  prdata[15:0] = target_addr_low_q;
            `FWC_A_ADDR_HIGH: prdata[15:0] = target_addr_high_q;
            `FWC_A_WD0_LOW:   prdata[15:0] = wdata0_low_q;
            `FWC_A_WD0_HIGH:  prdata[15:0] = wdata0_high_q;
            `FWC_A_WD1_LOW:   prdata[15:0] = wdata1_low_q;
            `FWC_A_WD1_HIGH:  prdata[15:0] = wdata1_high_q;
            `FWC_A_ERROR:     prdata[1:0]  = error_reg_q;
            `FWC_A_STATUS:    prdata = {nv_access_q | unprot_access_q,
                                        nv_wprot_q[15:8] |
                                        unprot_wprot_q[15:8],
                                        perm_cnt_q, state_q};
            default: begin
               if (mapped && paddr >= `FWC_A_PROT_BASE)
                  prdata[15:0] = nv_rd;
            end
         endcase
      end
   end
endmodule // fwc_ctrl
`default_nettype wire

// [tb/fwc_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the flash write controller
module fwc_ctrl_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        flash_busy,
   input wire logic        flash_wr_en,
   input wire logic        flash_erase_en,
   input wire logic        flash_ext_sel
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Word program start written while idle
   sequence s_word_start;
      psel && penable && pwrite && paddr == 12'h004
         && pwdata[15:0] == 16'hA000 && !flash_busy;
   endsequence
   // Program strobe follows within a few edges
   sequence s_prog_on;
      ##[1:4] flash_wr_en;
   endsequence
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_bad_addr_err: assert property (psel && penable
      && (paddr >= 12'h040 || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("no error on unmapped access");
   a_good_addr_ok: assert property (psel && penable
      && paddr < 12'h040 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped access");
   a_idle_rdata: assert property (!(psel && penable && !pwrite)
      |-> prdata == 32'h0) else $error("read data outside read");
   a_word_launch: assert property (s_word_start |-> s_prog_on)
      else $error("start did not launch program");
   a_prog_busy: assert property (flash_wr_en |-> flash_busy)
      else $error("program without busy");
   a_erase_busy: assert property (flash_erase_en |-> flash_busy)
      else $error("erase without busy");
   a_excl_ops: assert property (!(flash_wr_en && flash_erase_en))
      else $error("program and erase together");
   a_module_hold: assert property (flash_wr_en && $past(flash_wr_en)
      |-> $stable(flash_ext_sel)) else $error("module changed in program");
endmodule // fwc_ctrl_monitor
bind fwc_ctrl fwc_ctrl_monitor fwc_ctrl_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .flash_busy(flash_busy),
   .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en),
   .flash_ext_sel(flash_ext_sel)
);
`default_nettype wire

// [tb/flash_write_op_controller_test.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_write_op_controller_test;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, flash_addr, flash_wdata, rd, rd_q, addr_q;
   logic        pready, pslverr, flash_busy, flash_wr_en, flash_erase_en;
   logic        flash_ext_sel, slv_q, wr_q;
   logic [64:0] progs[$];
   int          err_total, checked, i, er_cyc;

   fwc_ctrl fwc_ctrl_i (
      .pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_busy(flash_busy),
      .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en),
      .flash_ext_sel(flash_ext_sel), .flash_addr(flash_addr),
      .flash_wdata(flash_wdata)
   );

   // Clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Capture read answers, program phases and erase activity
   always @(posedge pclk) begin
      if (psel && penable && !pwrite) begin
         rd_q <= prdata;
         slv_q <= pslverr;
      end
      if (flash_wr_en && (!wr_q || flash_addr != addr_q))
         progs.push_back({flash_ext_sel, flash_addr, flash_wdata});
      if (flash_erase_en)
         er_cyc <= er_cyc + 1;
      wr_q <= flash_wr_en;
      addr_q <= flash_addr;
   end

   task automatic report_and_stop(input bit hung);
      if (hung)
         err_total++;
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer, held until pready, then one idle cycle
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         report_and_stop(1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      rd = rd_q;
   endtask

   // Read twice, since the protection store answers one cycle late
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      do begin
         xfer(1'b0, 12'h004, 32'h0);
         n++;
      end while (rd[15] !== 1'b0 && n < 200);
      if (n >= 200)
         report_and_stop(1'b1);
   endtask

   task automatic prog(input logic [15:0] sel, input logic [15:0] alo,
                       input logic [15:0] ahi, input logic [63:0] d);
      xfer(1'b1, 12'h004, {16'h0, sel});
      xfer(1'b1, 12'h010, {16'h0, alo});
      xfer(1'b1, 12'h014, {16'h0, ahi});
      xfer(1'b1, 12'h018, {16'h0, d[15:0]});
      xfer(1'b1, 12'h01C, {16'h0, d[31:16]});
      xfer(1'b1, 12'h020, {16'h0, d[47:32]});
      xfer(1'b1, 12'h024, {16'h0, d[63:48]});
      xfer(1'b1, 12'h004, {16'h0, sel | 16'h8000});
      wait_done();
   endtask

   task automatic pchk(input logic [64:0] e);
      logic [64:0] s;
      s = 65'h0;
      if (progs.size() > 0)
         s = progs.pop_front();
      chk(s, e);
   endtask

   // Start an erase of two bank 3 sectors, then suspend it
   task automatic erase_suspend_bit();
      xfer(1'b1, 12'h004, 32'h0800);
      xfer(1'b1, 12'h00C, 32'h0003);
      xfer(1'b1, 12'h004, 32'h8800);
      xfer(1'b0, 12'h004, 32'h0);
      xfer(1'b1, 12'h004, rd | 32'h4000);
      repeat (10) @(posedge pclk);
   endtask

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      err_total = 0;
      checked = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(12'h004, 32'h0);
      rchk(12'h030, 32'hFFFF);
      rchk(12'h040, 32'h0);
      chk(slv_q, 1'b1);
      prog(16'h2000, 16'h5554, 16'h000C, 64'hAAAAAAAA);
      pchk({1'b1, 32'h000C5554, 32'hAAAAAAAA});
      rchk(12'h004, 32'h0);
      prog(16'h1080, 16'h555C, 16'h0009, 64'hAA55AA55_55AA55AA);
      pchk({1'b0, 32'h00095558, 32'h55AA55AA});
      pchk({1'b0, 32'h0009555C, 32'hAA55AA55});
      xfer(1'b1, 12'h004, 32'h2000);
      xfer(1'b1, 12'h004, 32'h0);
      xfer(1'b1, 12'h004, 32'h8000);
      repeat (60) @(posedge pclk);
      chk(progs.size(), 0);
      rchk(12'h004, 32'h0);
      i = er_cyc;
      erase_suspend_bit();
      chk(er_cyc > i, 1'b1);
      chk(flash_erase_en, 1'b0);
      prog(16'h2000, 16'h5554, 16'h000C, 64'h5555AAAA);
      pchk({1'b1, 32'h000C5554, 32'h5555AAAA});
      xfer(1'b1, 12'h004, 32'h2000);
      xfer(1'b1, 12'h004, 32'hA000);
      xfer(1'b1, 12'h004, 32'hE000);
      wait_done();
      rchk(12'h004, 32'h4000);
      pchk({1'b1, 32'h000C5554, 32'h5555AAAA});
      xfer(1'b1, 12'h004, 32'h0800);
      xfer(1'b1, 12'h004, 32'h8800);
      wait_done();
      rchk(12'h00C, 32'h0);
      rchk(12'h008, 32'h0);
      rchk(12'h028, 32'h0);
      erase_suspend_bit();
      xfer(1'b1, 12'h004, 32'h0);
      xfer(1'b1, 12'h004, 32'h8000);
      rchk(12'h028, 32'h1);
      rchk(12'h004, 32'h0);
      xfer(1'b1, 12'h028, 32'h1);
      rchk(12'h028, 32'h0);
      prog(16'h0100, 16'hDFB4, 16'h000E, 64'hFFFFFFF0);
      rchk(12'h030, 32'hFFF0);
      prog(16'h0100, 16'hDFB8, 16'h000E, 64'hFFFFFFFC);
      rchk(12'h034, 32'hFFFC);
      prog(16'h0100, 16'hDFBC, 16'h000E, 64'hFFFFFFFE);
      rchk(12'h038, 32'hFFFE);
      prog(16'h0100, 16'hDFBC, 16'h000E, 64'hFFFEFFFF);
      rchk(12'h03C, 32'hFFFE);
      prog(16'h0100, 16'hDFB8, 16'h000E, 64'hFFFFFFFF);
      xfer(1'b0, 12'h02C, 32'h0);
      chk(rd[31:16], 16'hFFFF);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(12'h034, 32'hFFFC);
      rchk(12'h030, 32'hFFF0);
      xfer(1'b0, 12'h02C, 32'h0);
      chk(rd[31:16], 16'hFFFC);
      for (i = 0; i < 14; i++) begin
         prog(16'h0100, 16'hDFBC, 16'h000E,
              i[0] ? 64'hFFFEFFFF : 64'hFFFFFFFE);
      end
      rchk(12'h028, 32'h0);
      prog(16'h0100, 16'hDFBC, 16'h000E, 64'hFFFFFFFE);
      xfer(1'b0, 12'h028, 32'h0);
      chk(rd[1], 1'b1);
      report_and_stop(1'b0);
   end
endmodule // flash_write_op_controller_test
`default_nettype wire
